//--- hw/rtc_ctrl.sv
// clock-control and alarm-control logic of the real-time clock, AHB-Lite slave
//
// Functional notes
// - calibration is signed; positive N inserts N extra pulses every minute.
// - negative calibration removes pulses per minute, one up to 512.
// - module runs only when on; on is writable only with write-enable set.
// - stop-in-idle gates the bus clock to the module while processor idles.
// - output select one routes seconds clock to pin, zero the alarm pulse.
// - pin is driven only while output enable is one.
// - read-only running status is one while the module is on and the clock source runs.
// - time/date value writes are accepted only while write-enable is one.
// - write-enable can be set only after the system unlock is open.
// - value sync flag is one while a rollover ripple may disturb reads.
// - half-second status is one in second half; cleared by seconds writes.
// - alarms only while enabled; cleared at event with count zero, chime off.
// - chime on wraps repeat count zero to maximum; off stops at zero.
// - pulse level writable while alarm disabled; reads live pulse when enabled.
// - alarm sync is one within 32 clocks of a half-second rollover.
// - mask codes zero to nine select half-second up to yearly intervals.
// - both control registers are cleared only by power-on reset.
// - repeat count decrements every alarm event but holds at zero with chime off; with chime off N gives N plus one alarms.
// - time value holds BCD hours, minutes, seconds; writable with write-enable.
//
// The AHB-Lite interface to the registers and the register addresses were decided locally.
`timescale 1ns/1ps

module rtc_ctrl
  import rtc_ctrl_pkg::*;
#(
  parameter int LOSS_CYCLES = 2 * RTC_PERIOD_CYC
)(
  // clock and power-on reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // system side
  input  wire logic        rtc_clk_pin,
  input  wire logic        cpu_idle,
  input  wire logic        unlock_open,
  input  wire cal_tick_t   cal_tick,
  input  wire logic        alarm_match,
  output logic             bus_clk_run,
  output logic             alarm_evt,
  // output pin
  output logic             rtc_pin_out,
  output logic             rtc_pin_oe
);

  if (LOSS_CYCLES < RTC_PERIOD_CYC + 1 || LOSS_CYCLES > 65535)
    $error("rtc_ctrl: LOSS_CYCLES out of range");

  ////////////////////////////////////////////////////////////////////////////
  // state

  clock_control_t cc_ff;
  alarm_control_t ac_ff;
  logic           pulse_ff;
  logic [31:0]    time_ff;
  logic [14:0]    presc_ff;
  logic [5:0]     sec_cnt_ff;
  logic [9:0]     cal_left_ff;
  logic           cal_neg_ff;
  logic [15:0]    loss_ff;
  logic [2:0]     rtc_sync_ff;
  logic           wr_pend_ff;
  logic           rd_pend_ff;
  logic [11:0]    addr_ff;
  logic [31:0]    hrdata_ff;
  logic           hreadyout_ff;
  logic           bus_clk_run_ff;
  logic           alarm_evt_ff;
  logic           pin_out_ff;
  logic           pin_oe_ff;

  ////////////////////////////////////////////////////////////////////////////
  // rtc clock edge detect; stage 0 is read only by stage 1

  logic rtc_tick;
  logic clk_running;
  assign rtc_tick    = rtc_sync_ff[1] & ~rtc_sync_ff[2];
  assign clk_running = (loss_ff != 16'h0000);

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      rtc_sync_ff <= 3'h0;
    else
      rtc_sync_ff <= {rtc_sync_ff[1:0], rtc_clk_pin};
  end

  // running status drops once no edge is seen for LOSS_CYCLES
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      loss_ff <= 16'h0000;
    else if (rtc_tick)
      loss_ff <= 16'(LOSS_CYCLES);
    else if (clk_running)
      loss_ff <= loss_ff - 16'h0001;
  end

  ////////////////////////////////////////////////////////////////////////////
  // bus decode

  logic        addr_phase;
  logic        wr_cc;
  logic        wr_ac;
  logic        wr_time;
  logic [1:0]  wr_op;
  logic [31:0] rd_cc;
  logic [31:0] rd_ac;
  logic [31:0] rd_mux;

  assign addr_phase = hsel & htrans[1] & hready;
  assign wr_op      = addr_ff[3:2];
  assign wr_cc      = wr_pend_ff & (addr_ff[11:4] == OFS_CLOCK_CONTROL[11:4]);
  assign wr_ac      = wr_pend_ff & (addr_ff[11:4] == OFS_ALARM_CONTROL[11:4]);
  assign wr_time    = wr_pend_ff & (addr_ff[11:4] == OFS_TIME_VALUE[11:4]);

  function automatic logic [31:0] apply_op(input logic [1:0] op,
                                           input logic [31:0] cur,
                                           input logic [31:0] d);
    case (op)
      OP_CLEAR:  apply_op = cur & ~d;
      OP_SET:    apply_op = cur | d;
      OP_INVERT: apply_op = cur ^ d;
      default:   apply_op = d;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // prescaler, half-second, minute and calibration

  logic [1:0]  step;
  logic [15:0] presc_sum;
  logic        sec_roll;
  logic        half_roll;
  logic        minute_roll;
  logic        val_sync;
  logic        alm_sync;
  logic        counting;
  logic [9:0]  cal_mag;
  logic        sec_write;

  assign counting  = cc_ff.on & clk_running;
  // inserted pulse doubles a step, removed pulse holds the count
  assign step      = (cal_left_ff == 10'h000) ? 2'h1 :
                     (cal_neg_ff ? 2'h0 : 2'h2);
  assign presc_sum = {1'b0, presc_ff} + {14'h0000, step};
  assign sec_roll  = counting & rtc_tick & presc_sum[15];
  assign half_roll = counting & rtc_tick & (presc_sum[14] != presc_ff[14]);
  assign minute_roll = sec_roll & (sec_cnt_ff == 6'(SEC_PER_MIN - 1));
  assign cal_mag   = cc_ff.cal[9] ? 10'(-cc_ff.cal) : cc_ff.cal;
  // ripple windows: last 32 rtc clocks before each rollover
  assign val_sync  = cc_ff.on & (presc_ff >= 15'(RTC_FREQ_HZ - SYNC_WINDOW_RTC));
  assign alm_sync  = cc_ff.on & (presc_ff[13:0] >= 14'(RTC_FREQ_HZ/2 - SYNC_WINDOW_RTC));
  // a plain write always rewrites the seconds digits, even with zeros
  assign sec_write = wr_time & cc_ff.value_write_enable &
                     ((wr_op == OP_WRITE) | ((hwdata & TIME_SEC_MASK) != 32'h0));

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      presc_ff <= 15'h0000;
    else if (sec_write)
      presc_ff <= 15'h0000;
    else if (counting && rtc_tick)
      presc_ff <= presc_sum[14:0];
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      sec_cnt_ff <= 6'h00;
    else if (minute_roll)
      sec_cnt_ff <= 6'h00;
    else if (sec_roll)
      sec_cnt_ff <= sec_cnt_ff + 6'h01;
  end

  // at each minute boundary reload the pulses to insert or remove
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      cal_left_ff <= 10'h000;
      cal_neg_ff  <= 1'b0;
    end
    else if (minute_roll)
    begin
      cal_left_ff <= cal_mag;
      cal_neg_ff  <= cc_ff.cal[9];
    end
    else if (counting && rtc_tick && cal_left_ff != 10'h000)
      cal_left_ff <= cal_left_ff - 10'h001;
  end

  ////////////////////////////////////////////////////////////////////////////
  // clock_control register (power-on reset only)

  logic [31:0] cc_new;
  assign rd_cc = {6'h00, cc_ff.cal, cc_ff.on, 1'b0, cc_ff.stop_in_idle, 5'h00,
                  cc_ff.output_source_select, cc_ff.on & clk_running, 2'h0,
                  cc_ff.value_write_enable, val_sync, presc_ff[14],
                  cc_ff.output_pin_enable};
  assign cc_new = apply_op(wr_op, rd_cc, hwdata);

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      cc_ff <= clock_control_t'({CLOCK_CONTROL_RST[CC_CAL_LSB +: CC_CAL_W],
                                 CLOCK_CONTROL_RST[CC_ON],
                                 CLOCK_CONTROL_RST[CC_STOP_IDLE],
                                 CLOCK_CONTROL_RST[CC_OUT_SEL],
                                 CLOCK_CONTROL_RST[CC_WREN],
                                 CLOCK_CONTROL_RST[CC_PIN_OE]});
    else if (wr_cc)
    begin
      cc_ff.cal                  <= cc_new[CC_CAL_LSB +: CC_CAL_W];
      cc_ff.stop_in_idle         <= cc_new[CC_STOP_IDLE];
      cc_ff.output_source_select <= cc_new[CC_OUT_SEL];
      cc_ff.output_pin_enable    <= cc_new[CC_PIN_OE];
      if (cc_ff.value_write_enable)
        cc_ff.on <= cc_new[CC_ON];
      // setting needs the unlock, clearing is always allowed
      if (!cc_new[CC_WREN] || unlock_open)
        cc_ff.value_write_enable <= cc_new[CC_WREN];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // time value storage; BCD counting lives in the calendar unit

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      time_ff <= 32'h00000000;
    else if (wr_time && cc_ff.value_write_enable)
      time_ff <= apply_op(wr_op, time_ff, hwdata) & TIME_WR_MASK;
  end

  ////////////////////////////////////////////////////////////////////////////
  // alarm event and alarm_control register

  logic        interval_tick;
  logic        alarm_hit;
  logic [31:0] ac_new;

  // a yearly alarm on a leap day matches only in leap years
  always_comb
  begin
    case (ac_ff.alarm_interval_mask)
      MASK_HALF_SEC: interval_tick = half_roll;
      MASK_SEC:      interval_tick = sec_roll;
      MASK_TEN_SEC:  interval_tick = cal_tick.ten_sec;
      MASK_MIN:      interval_tick = cal_tick.minute;
      MASK_TEN_MIN:  interval_tick = cal_tick.ten_min;
      MASK_HOUR:     interval_tick = cal_tick.hour;
      MASK_DAY:      interval_tick = cal_tick.day;
      MASK_WEEK:     interval_tick = cal_tick.week;
      MASK_MONTH:    interval_tick = cal_tick.month;
      MASK_YEAR:     interval_tick = cal_tick.year;
      default:       interval_tick = 1'b0;
    endcase
  end

  assign alarm_hit = cc_ff.on & ac_ff.alarm_enable & interval_tick & alarm_match;
  assign rd_ac  = {16'h0000, ac_ff.alarm_enable, ac_ff.chime, pulse_ff, alm_sync,
                   ac_ff.alarm_interval_mask, ac_ff.alarm_repeat_count};
  assign ac_new = apply_op(wr_op, rd_ac, hwdata);

  // an alarm in the same cycle as a write takes precedence over the write
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ac_ff    <= alarm_control_t'({ALARM_CONTROL_RST[AC_ENABLE],
                                    ALARM_CONTROL_RST[AC_CHIME],
                                    ALARM_CONTROL_RST[AC_MASK_LSB +: 4],
                                    ALARM_CONTROL_RST[AC_RPT_LSB +: 8]});
      pulse_ff <= ALARM_CONTROL_RST[AC_PULSE];
    end
    else if (alarm_hit)
    begin
      pulse_ff <= ~pulse_ff;
      if (ac_ff.alarm_repeat_count != 8'h00)
        ac_ff.alarm_repeat_count <= ac_ff.alarm_repeat_count - 8'h01;
      else if (ac_ff.chime)
        ac_ff.alarm_repeat_count <= RPT_MAX;
      else
        ac_ff.alarm_enable <= 1'b0;
    end
    else if (wr_ac)
    begin
      ac_ff.alarm_enable        <= ac_new[AC_ENABLE];
      ac_ff.chime               <= ac_new[AC_CHIME];
      ac_ff.alarm_interval_mask <= ac_new[AC_MASK_LSB +: 4];
      ac_ff.alarm_repeat_count  <= ac_new[AC_RPT_LSB +: 8];
      if (!ac_ff.alarm_enable)
        pulse_ff <= ac_new[AC_PULSE];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // AHB-Lite slave: writes take no wait, reads one wait state

  assign rd_mux = (addr_ff[11:4] == OFS_CLOCK_CONTROL[11:4]) ? rd_cc :
                  (addr_ff[11:4] == OFS_ALARM_CONTROL[11:4]) ? rd_ac :
                  (addr_ff[11:4] == OFS_TIME_VALUE[11:4])    ? time_ff : 32'h00000000;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend_ff   <= 1'b0;
      rd_pend_ff   <= 1'b0;
      addr_ff      <= 12'h000;
      hrdata_ff    <= 32'h00000000;
      hreadyout_ff <= 1'b1;
    end
    else
    begin
      wr_pend_ff   <= addr_phase & hwrite;
      rd_pend_ff   <= addr_phase & ~hwrite;
      hreadyout_ff <= ~(addr_phase & ~hwrite);
      if (addr_phase)
        addr_ff <= haddr[11:0];
      if (rd_pend_ff)
        hrdata_ff <= rd_mux;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pin, idle gate and event outputs

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      bus_clk_run_ff <= 1'b1;
      alarm_evt_ff   <= 1'b0;
      pin_out_ff     <= 1'b0;
      pin_oe_ff      <= 1'b0;
    end
    else
    begin
      bus_clk_run_ff <= ~(cc_ff.stop_in_idle & cpu_idle);
      alarm_evt_ff   <= alarm_hit;
      pin_out_ff     <= cc_ff.output_source_select ? presc_ff[14] : pulse_ff;
      pin_oe_ff      <= cc_ff.output_pin_enable & cc_ff.on;
    end
  end

  assign hrdata      = hrdata_ff;
  assign hreadyout   = hreadyout_ff;
  assign hresp       = 1'b0;
  assign bus_clk_run = bus_clk_run_ff;
  assign alarm_evt   = alarm_evt_ff;
  assign rtc_pin_out = pin_out_ff;
  assign rtc_pin_oe  = pin_oe_ff;

endmodule // rtc_ctrl

//--- include/rtc_ctrl_pkg.sv
// constants, field layouts and carriers of the clock-control and alarm-control block
package rtc_ctrl_pkg;

  // register byte offsets (low 12 address bits) and set/clear/invert aliases
  localparam logic [11:0] OFS_CLOCK_CONTROL = 12'h200;
  localparam logic [11:0] OFS_ALARM_CONTROL = 12'h210;
  localparam logic [11:0] OFS_TIME_VALUE    = 12'h220;
  localparam logic [1:0]  OP_WRITE          = 2'h0;
  localparam logic [1:0]  OP_CLEAR          = 2'h1;
  localparam logic [1:0]  OP_SET            = 2'h2;
  localparam logic [1:0]  OP_INVERT         = 2'h3;

  // clock_control field positions
  localparam int CC_CAL_LSB      = 16;
  localparam int CC_CAL_W        = 10;
  localparam int CC_ON           = 15;
  localparam int CC_STOP_IDLE    = 13;
  localparam int CC_OUT_SEL      = 7;
  localparam int CC_CLK_RUN      = 6;
  localparam int CC_WREN         = 3;
  localparam int CC_VAL_SYNC     = 2;
  localparam int CC_HALF_SEC     = 1;
  localparam int CC_PIN_OE       = 0;

  // alarm_control field positions
  localparam int AC_ENABLE       = 15;
  localparam int AC_CHIME        = 14;
  localparam int AC_PULSE        = 13;
  localparam int AC_SYNC         = 12;
  localparam int AC_MASK_LSB     = 8;
  localparam int AC_RPT_LSB      = 0;

  // time_value: seconds in bits 14:8, low byte unimplemented
  localparam logic [31:0] TIME_WR_MASK  = 32'hffffff00;
  localparam logic [31:0] TIME_SEC_MASK = 32'h00007f00;

  // interval mask codes
  localparam logic [3:0] MASK_HALF_SEC = 4'h0;
  localparam logic [3:0] MASK_SEC      = 4'h1;
  localparam logic [3:0] MASK_TEN_SEC  = 4'h2;
  localparam logic [3:0] MASK_MIN      = 4'h3;
  localparam logic [3:0] MASK_TEN_MIN  = 4'h4;
  localparam logic [3:0] MASK_HOUR     = 4'h5;
  localparam logic [3:0] MASK_DAY      = 4'h6;
  localparam logic [3:0] MASK_WEEK     = 4'h7;
  localparam logic [3:0] MASK_MONTH    = 4'h8;
  localparam logic [3:0] MASK_YEAR     = 4'h9;

  // timing
  localparam int RTC_FREQ_HZ     = 32768;
  localparam int HCLK_FREQ_HZ    = 200000000;
  localparam int RTC_PERIOD_CYC  = HCLK_FREQ_HZ / RTC_FREQ_HZ;
  localparam int SYNC_WINDOW_RTC = 32;
  localparam int SEC_PER_MIN     = 60;
  localparam logic [7:0] RPT_MAX = 8'hff;

  // reset values (power-on only)
  localparam logic [31:0] CLOCK_CONTROL_RST = 32'h00000000;
  localparam logic [31:0] ALARM_CONTROL_RST = 32'h00000000;

  typedef struct packed {
    logic [9:0] cal;
    logic       on;
    logic       stop_in_idle;
    logic       output_source_select;
    logic       value_write_enable;
    logic       output_pin_enable;
  } clock_control_t;

  typedef struct packed {
    logic       alarm_enable;
    logic       chime;
    logic [3:0] alarm_interval_mask;
    logic [7:0] alarm_repeat_count;
  } alarm_control_t;

  // boundary pulses from the calendar counters, one hclk cycle each
  typedef struct packed {
    logic ten_sec;
    logic minute;
    logic ten_min;
    logic hour;
    logic day;
    logic week;
    logic month;
    logic year;
  } cal_tick_t;

endpackage

//--- sim/rtc_ctrl_sva.sv
// concurrent checks on the ports of the rtc clock-control and alarm-control block
`timescale 1ns/1ps

module rtc_ctrl_sva
  import rtc_ctrl_pkg::*;
#(
  parameter int LOSS_CYCLES = 2 * RTC_PERIOD_CYC
)(
  // clock and reset
  input wire logic        hclk,
  input wire logic        hresetn,
  // bus
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [2:0]  hsize,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic [31:0] hrdata,
  input wire logic        hreadyout,
  input wire logic        hresp,
  // system side
  input wire logic        rtc_clk_pin,
  input wire logic        cpu_idle,
  input wire logic        unlock_open,
  input wire cal_tick_t   cal_tick,
  input wire logic        alarm_match,
  input wire logic        bus_clk_run,
  input wire logic        alarm_evt,
  // pin
  input wire logic        rtc_pin_out,
  input wire logic        rtc_pin_oe
);

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  wire logic       take_rd = hsel & htrans[1] & hready & ~hwrite;
  wire logic       take_wr = hsel & htrans[1] & hready & hwrite;
  logic      [3:0] wr_hist_ff;
  wire logic [3:0] nxt_wr_hist = {wr_hist_ff[2:0], take_wr};

  // pin enable only follows register state, so it may move only just after a write
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      wr_hist_ff <= 4'h0;
    else
      wr_hist_ff <= nxt_wr_hist;
  end

  ////////////////////////////////////////////////////////////////////////////////

  hresp_okay_a: assert property (hresp == 1'b0)
    else $error("slave answered other than okay");
  read_wait_a: assert property (take_rd |=> !hreadyout ##1 hreadyout)
    else $error("read wait state not exactly one cycle");
  ready_idle_a: assert property (!take_rd |=> hreadyout)
    else $error("wait state without a read");
  rdata_hold_a: assert property ($changed(hrdata) |-> $rose(hreadyout))
    else $error("read data moved outside a read");
  oe_cause_a: assert property ($changed(rtc_pin_oe) |-> |wr_hist_ff)
    else $error("pin enable moved without a register write");
  idle_gate_a: assert property (!cpu_idle |=> bus_clk_run)
    else $error("bus clock gated while processor busy");
  evt_cause_a: assert property (alarm_evt |-> $past(alarm_match))
    else $error("alarm event without a compare match");
  evt_pulse_a: assert property (alarm_evt |=> !alarm_evt)
    else $error("alarm event longer than one cycle");

endmodule // rtc_ctrl_sva

bind rtc_ctrl rtc_ctrl_sva #(.LOSS_CYCLES(LOSS_CYCLES)) u_sva (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
  .hreadyout(hreadyout), .hresp(hresp), .rtc_clk_pin(rtc_clk_pin), .cpu_idle(cpu_idle),
  .unlock_open(unlock_open), .cal_tick(cal_tick), .alarm_match(alarm_match),
  .bus_clk_run(bus_clk_run), .alarm_evt(alarm_evt), .rtc_pin_out(rtc_pin_out),
  .rtc_pin_oe(rtc_pin_oe)
);

//--- sim/test_rtc_control_and_alarm_config.sv
// self-checking bench for the rtc clock-control and alarm-control block
`timescale 1ns/1ps

module test_rtc_control_and_alarm_config
  import rtc_ctrl_pkg::*;
;
  localparam int          LOSS = 6104;
  localparam logic [31:0] WREN = 32'h1 << CC_WREN;
  localparam logic [31:0] ON   = 32'h1 << CC_ON;
  localparam logic [31:0] OE   = 32'h1 << CC_PIN_OE;
  localparam logic [31:0] SEL  = 32'h1 << CC_OUT_SEL;
  localparam logic [31:0] STOP = 32'h1 << CC_STOP_IDLE;
  localparam logic [31:0] RUN  = 32'h1 << CC_CLK_RUN;
  localparam logic [31:0] HALF = 32'h1 << CC_HALF_SEC;
  localparam logic [31:0] BASE = WREN | ON | OE | 32'h02000000;

  logic        hclk = 1'b0;
  logic        hresetn, hsel, hwrite, cpu_idle, unlock_open, alarm_match, pin_run;
  logic [31:0] haddr, hwdata, hrdata, q;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [7:0]  t;
  logic [2:0]  div = 3'h0;
  logic        rtc_clk_pin = 1'b0;
  logic        fast        = 1'b0;
  cal_tick_t   cal_tick;
  logic        hreadyout, hresp, bus_clk_run, alarm_evt, rtc_pin_out, rtc_pin_oe;
  int          n_fail, tests_run, cyc, n;

  rtc_ctrl #(.LOSS_CYCLES(LOSS)) uut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .rtc_clk_pin(rtc_clk_pin),
    .cpu_idle(cpu_idle), .unlock_open(unlock_open), .cal_tick(cal_tick),
    .alarm_match(alarm_match), .bus_clk_run(bus_clk_run), .alarm_evt(alarm_evt),
    .rtc_pin_out(rtc_pin_out), .rtc_pin_oe(rtc_pin_oe)
  );

  always #2.5 hclk = ~hclk;

  // fast stand-in for the crystal; stands low when stopped
  always @(posedge hclk)
  begin
    div <= div + 3'h1;
    rtc_clk_pin <= pin_run & (fast ? ~rtc_clk_pin : div[2]);
  end

  always @(posedge hclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 60000)
    begin
      n_fail++;
      report_and_stop();
    end
  end

  ////////////////////////////////////////////////////////////////////////////////

  task automatic report_and_stop();
    if (n_fail == 0 && tests_run > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      n_fail++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] r);
    hsel   <= 1'b1;
    htrans <= 2'b10;
    haddr  <= {20'h0, a};
    hwrite <= w;
    do @(negedge hclk); while (hreadyout !== 1'b1);
    @(posedge hclk);
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    do @(negedge hclk); while (hreadyout !== 1'b1);
    r = hrdata;
    @(posedge hclk);
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    xfer(1'b1, a, d, r);
  endtask

  task automatic rc(input logic [11:0] a, input logic [31:0] e);
    logic [31:0] r;
    xfer(1'b0, a, 32'h0, r);
    chk(r, e);
  endtask

  task automatic settle();
    repeat (4) @(posedge hclk);
    @(negedge hclk);
  endtask

  task automatic pin_chk(input logic [1:0] e, input logic [1:0] m);
    settle();
    chk({30'h0, {rtc_pin_out, rtc_pin_oe} & m}, {30'h0, e});
    @(posedge hclk);
  endtask

  // tick and match last one cycle, event is looked at in the cycle after
  task automatic fire(input logic [7:0] tk, input logic m, input logic e);
    cal_tick    <= cal_tick_t'(tk);
    alarm_match <= m;
    @(posedge hclk);
    cal_tick    <= cal_tick_t'(8'h00);
    alarm_match <= 1'b0;
    @(negedge hclk);
    chk({31'h0, alarm_evt}, {31'h0, e});
    repeat (2) @(posedge hclk);
  endtask

  ////////////////////////////////////////////////////////////////////////////////

  initial
  begin
    hresetn = 1'b0; hsel = 1'b0; haddr = 32'h0; htrans = 2'h0; hwrite = 1'b0;
    hsize = 3'h2; hwdata = 32'h0; cpu_idle = 1'b0; unlock_open = 1'b0;
    cal_tick = cal_tick_t'(8'h00); alarm_match = 1'b0; pin_run = 1'b0;
    n_fail = 0; tests_run = 0; cyc = 0;
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rc(OFS_CLOCK_CONTROL, 32'h0);
    rc(OFS_ALARM_CONTROL, 32'h0);
    wr(12'h2f0, 32'hffffffff);
    rc(12'h2f0, 32'h0);
    wr(OFS_CLOCK_CONTROL, WREN | ON);
    rc(OFS_CLOCK_CONTROL, 32'h0);
    wr(OFS_TIME_VALUE, 32'h12345600);
    rc(OFS_TIME_VALUE, 32'h0);
    unlock_open <= 1'b1;
    wr(OFS_CLOCK_CONTROL, WREN);
    rc(OFS_CLOCK_CONTROL, WREN);
    wr(OFS_TIME_VALUE, 32'h123456ab);
    rc(OFS_TIME_VALUE, 32'h12345600);
    rc(OFS_TIME_VALUE, 32'h12345600);
    pin_run <= 1'b1;
    wr(OFS_CLOCK_CONTROL, BASE);
    repeat (40) @(posedge hclk);
    rc(OFS_CLOCK_CONTROL, BASE | RUN);
    pin_chk(2'b01, 2'b11);
    wr(OFS_ALARM_CONTROL, 32'h2000);
    pin_chk(2'b11, 2'b11);
    wr(OFS_CLOCK_CONTROL, BASE | SEL);
    pin_chk(2'b01, 2'b11);
    wr(OFS_CLOCK_CONTROL, BASE & ~OE);
    pin_chk(2'b00, 2'b01);
    wr(OFS_ALARM_CONTROL, 32'ha201);
    fire(8'h80, 1'b1, 1'b1);
    rc(OFS_ALARM_CONTROL, 32'h8200);
    fire(8'h80, 1'b1, 1'b1);
    rc(OFS_ALARM_CONTROL, 32'h2200);
    fire(8'h80, 1'b1, 1'b0);
    wr(OFS_ALARM_CONTROL, 32'he300);
    fire(8'h40, 1'b1, 1'b1);
    rc(OFS_ALARM_CONTROL, 32'hc3ff);
    for (int m = 2; m <= 9; m++)
    begin
      t = 8'h01 << (9 - m);
      wr(OFS_ALARM_CONTROL, {16'h0, 4'hc, m[3:0], 8'h05});
      fire(~t, 1'b1, 1'b0);
      fire(t, 1'b0, 1'b0);
      fire(t, 1'b1, 1'b1);
      xfer(1'b0, OFS_ALARM_CONTROL, 32'h0, q);
      chk(q & 32'hffffdfff, {16'h0, 4'hc, m[3:0], 8'h04});
    end
    cpu_idle <= 1'b1;
    settle();
    chk({31'h0, bus_clk_run}, 32'h1);
    @(posedge hclk);
    wr(OFS_CLOCK_CONTROL, BASE | STOP);
    settle();
    chk({31'h0, bus_clk_run}, 32'h0);
    @(posedge hclk);
    cpu_idle <= 1'b0;
    settle();
    chk({31'h0, bus_clk_run}, 32'h1);
    @(posedge hclk);
    // fast pin: a tick every two cycles brings the half-second rollover into reach
    fast        <= 1'b1;
    alarm_match <= 1'b1;
    wr(OFS_ALARM_CONTROL, 32'h0000c000);
    do xfer(1'b0, OFS_ALARM_CONTROL, 32'h0, q); while (!q[AC_SYNC]);
    n = 0;
    while (alarm_evt !== 1'b1 && n < 100)
    begin
      @(negedge hclk);
      n++;
    end
    chk({31'h0, n < 80}, 32'h1);
    @(posedge hclk);
    alarm_match <= 1'b0;
    xfer(1'b0, OFS_ALARM_CONTROL, 32'h0, q);
    chk(q & 32'hffffdfff, 32'h0000c0ff);
    rc(OFS_CLOCK_CONTROL, BASE | STOP | RUN | HALF);
    wr(OFS_TIME_VALUE, 32'h12340000);
    rc(OFS_CLOCK_CONTROL, BASE | STOP | RUN);
    pin_run <= 1'b0;
    repeat (LOSS + 30) @(posedge hclk);
    rc(OFS_CLOCK_CONTROL, BASE | STOP);
    wr(OFS_CLOCK_CONTROL + 12'h4, ON);
    @(posedge hclk);
    wr(OFS_CLOCK_CONTROL + 12'h8, SEL);
    wr(OFS_CLOCK_CONTROL + 12'hc, OE);
    rc(OFS_CLOCK_CONTROL, (BASE & ~(ON | OE)) | STOP | SEL);
    report_and_stop();
  end

endmodule // test_rtc_control_and_alarm_config
